// *** hw/jtdp_top.sv ***
// Test access port that feeds instruction words to the core.
// Assumes TCK from the probe, asynchronous to CLK_SYS; core takes words by valid/ready.
`timescale 1ns/1ps

module jtdp_fifo #(
    parameter int W = 32,
    parameter int D = 32,
    parameter int AW = 5
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic [W-1:0]  in_data,
    input  wire logic          in_valid,
    output logic               in_ready,
    output logic [W-1:0]       out_data,
    output logic               out_valid,
    input  wire logic          out_ready
);
    logic [W-1:0] mem [D];
    logic [AW:0]  wp_r;
    logic [AW:0]  rp_r;
    wire          full  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    wire          empty = (wp_r == rp_r);
    wire          push  = in_valid && !full;
    wire          pop   = out_ready && !empty;
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rp_r[AW-1:0]];

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wp_r[AW-1:0]] <= in_data;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_r <= '0;
            rp_r <= '0;
        end
        else
        begin
            wp_r <= wp_r + (AW+1)'(push);
            rp_r <= rp_r + (AW+1)'(pop);
        end
    end
endmodule

module jtdp_top (
    // System side
    input  wire logic        CLK_SYS,
    input  wire logic        RESET_N,
    // Probe link
    input  wire logic        TCK,
    input  wire logic        TMS,
    input  wire logic        TDI,
    input  wire logic        TRST_N,
    output logic             TDO_O,
    output logic             TDO_OE,
    // Core instruction stream
    output logic [31:0]      CORE_INSN,
    output logic             CORE_VALID,
    input  wire logic        CORE_READY,
    // Core state
    input  wire logic        CORE_HALTED
);
    jtdp_pkg::jtdp_state_t st_r;
    jtdp_pkg::jtdp_state_t st_nxt;
    logic [jtdp_pkg::IR_W-1:0] ir_r;
    logic [jtdp_pkg::IR_W-1:0] irsh_r;
    logic [jtdp_pkg::DR_W-1:0] dr_r;
    logic                      tdo_r;
    logic                      tdo_oe_r;
    logic                      tgl_r;
    logic [31:0]               word_r;
    logic                      drop_r;
    logic                      halt_s1_r;
    logic                      halt_s2_r;
    logic                      space_s1_r;
    logic                      space_s2_r;

    // Link-side state machine, moved by sampled TMS and forced to reset by TRST_N
    always_comb
    begin
        case (st_r)
            jtdp_pkg::JTDP_RESET:  st_nxt = TMS ? jtdp_pkg::JTDP_RESET  : jtdp_pkg::JTDP_IDLE;
            jtdp_pkg::JTDP_IDLE:   st_nxt = TMS ? jtdp_pkg::JTDP_SEL_DR : jtdp_pkg::JTDP_IDLE;
            jtdp_pkg::JTDP_SEL_DR: st_nxt = TMS ? jtdp_pkg::JTDP_SEL_IR : jtdp_pkg::JTDP_CAP_DR;
            jtdp_pkg::JTDP_CAP_DR: st_nxt = TMS ? jtdp_pkg::JTDP_EX1_DR : jtdp_pkg::JTDP_SH_DR;
            jtdp_pkg::JTDP_SH_DR:  st_nxt = TMS ? jtdp_pkg::JTDP_EX1_DR : jtdp_pkg::JTDP_SH_DR;
            jtdp_pkg::JTDP_EX1_DR: st_nxt = TMS ? jtdp_pkg::JTDP_UPD_DR : jtdp_pkg::JTDP_PAU_DR;
            jtdp_pkg::JTDP_PAU_DR: st_nxt = TMS ? jtdp_pkg::JTDP_EX2_DR : jtdp_pkg::JTDP_PAU_DR;
            jtdp_pkg::JTDP_EX2_DR: st_nxt = TMS ? jtdp_pkg::JTDP_UPD_DR : jtdp_pkg::JTDP_SH_DR;
            jtdp_pkg::JTDP_UPD_DR: st_nxt = TMS ? jtdp_pkg::JTDP_SEL_DR : jtdp_pkg::JTDP_IDLE;
            jtdp_pkg::JTDP_SEL_IR: st_nxt = TMS ? jtdp_pkg::JTDP_RESET  : jtdp_pkg::JTDP_CAP_IR;
            jtdp_pkg::JTDP_CAP_IR: st_nxt = TMS ? jtdp_pkg::JTDP_EX1_IR : jtdp_pkg::JTDP_SH_IR;
            jtdp_pkg::JTDP_SH_IR:  st_nxt = TMS ? jtdp_pkg::JTDP_EX1_IR : jtdp_pkg::JTDP_SH_IR;
            jtdp_pkg::JTDP_EX1_IR: st_nxt = TMS ? jtdp_pkg::JTDP_UPD_IR : jtdp_pkg::JTDP_PAU_IR;
            jtdp_pkg::JTDP_PAU_IR: st_nxt = TMS ? jtdp_pkg::JTDP_EX2_IR : jtdp_pkg::JTDP_PAU_IR;
            jtdp_pkg::JTDP_EX2_IR: st_nxt = TMS ? jtdp_pkg::JTDP_UPD_IR : jtdp_pkg::JTDP_SH_IR;
            jtdp_pkg::JTDP_UPD_IR: st_nxt = TMS ? jtdp_pkg::JTDP_SEL_DR : jtdp_pkg::JTDP_IDLE;
            default:               st_nxt = jtdp_pkg::JTDP_RESET;
        endcase
    end

    wire sh_dr   = (st_r == jtdp_pkg::JTDP_SH_DR);
    wire sh_ir   = (st_r == jtdp_pkg::JTDP_SH_IR);
    wire cap_dr  = (st_r == jtdp_pkg::JTDP_CAP_DR);
    wire upd_dr  = (st_r == jtdp_pkg::JTDP_UPD_DR);
    wire sel_exe = (ir_r == jtdp_pkg::IR_EXEC);
    wire sel_byp = (ir_r == jtdp_pkg::IR_BYPASS) || (ir_r == jtdp_pkg::IR_RESET);
    wire [31:0] cap_val = (ir_r == jtdp_pkg::IR_IDCODE) ? jtdp_pkg::ID_VALUE :
                          (ir_r == jtdp_pkg::IR_STATUS) ?
                          {30'h0000_0000, halt_s2_r, space_s2_r} : 32'h0000_0000;
    wire [jtdp_pkg::DR_W-1:0] dr_sh = sel_byp ? {31'h0000_0000, TDI}
                                              : {TDI, dr_r[jtdp_pkg::DR_W-1:1]};
    wire tdo_nxt = sh_ir ? irsh_r[0] : dr_r[0];

    always_ff @(posedge TCK or negedge TRST_N)
    begin
        if (!TRST_N)
        begin
            st_r   <= jtdp_pkg::JTDP_RESET;
            ir_r   <= jtdp_pkg::IR_IDCODE;
            irsh_r <= '0;
            dr_r   <= '0;
        end
        else
        begin
            st_r <= st_nxt;
            if (st_r == jtdp_pkg::JTDP_RESET)
                ir_r <= jtdp_pkg::IR_IDCODE;
            else if (st_r == jtdp_pkg::JTDP_UPD_IR)
                ir_r <= irsh_r;
            if (st_r == jtdp_pkg::JTDP_CAP_IR)
                irsh_r <= jtdp_pkg::IR_RESET;
            else if (sh_ir)
                irsh_r <= {TDI, irsh_r[jtdp_pkg::IR_W-1:1]};
            if (cap_dr)
                dr_r <= cap_val;
            else if (sh_dr)
                dr_r <= dr_sh;
        end
    end

    // Handing a word over: toggle crosses, word held stable until next update
    always_ff @(posedge TCK or negedge TRST_N)
    begin
        if (!TRST_N)
        begin
            tgl_r  <= 1'b0;
            word_r <= '0;
        end
        else if (upd_dr && sel_exe)
        begin
            tgl_r  <= ~tgl_r;
            word_r <= dr_r;
        end
    end

    // Output moves on the falling edge so the probe samples a settled bit
    always_ff @(negedge TCK or negedge TRST_N)
    begin
        if (!TRST_N)
        begin
            tdo_r    <= 1'b0;
            tdo_oe_r <= 1'b0;
        end
        else
        begin
            tdo_r    <= tdo_nxt;
            tdo_oe_r <= sh_dr || sh_ir;
        end
    end
    assign TDO_O  = tdo_r;
    assign TDO_OE = tdo_oe_r;

    // Status levels into the link domain
    always_ff @(posedge TCK or negedge TRST_N)
    begin
        if (!TRST_N)
        begin
            halt_s1_r  <= 1'b0;
            halt_s2_r  <= 1'b0;
            space_s1_r <= 1'b0;
            space_s2_r <= 1'b0;
        end
        else
        begin
            halt_s1_r  <= CORE_HALTED;
            halt_s2_r  <= halt_s1_r;
            space_s1_r <= ~drop_r;
            space_s2_r <= space_s1_r;
        end
    end

    // System domain: synchronise toggle, push word into FIFO
    logic t1_r;
    logic t2_r;
    logic t3_r;
    logic fifo_in_rdy;
    logic [31:0] fifo_q;
    logic fifo_v;
    logic [31:0] insn_r;
    logic valid_r;
    wire  new_word = t2_r ^ t3_r;
    wire  take_out = fifo_v && (!valid_r || CORE_READY);

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            t1_r   <= 1'b0;
            t2_r   <= 1'b0;
            t3_r   <= 1'b0;
            drop_r <= 1'b0;
        end
        else
        begin
            t1_r   <= tgl_r;
            t2_r   <= t1_r;
            t3_r   <= t2_r;
            // Full FIFO loses the word; host sees it via status
            drop_r <= !fifo_in_rdy;
        end
    end

    jtdp_fifo #(
        .W  (jtdp_pkg::DR_W),
        .D  (jtdp_pkg::FIFO_DEPTH),
        .AW (jtdp_pkg::FIFO_AW)
    ) u_fifo (
        .clk       (CLK_SYS),
        .rst_n     (RESET_N),
        .in_data   (word_r),
        .in_valid  (new_word),
        .in_ready  (fifo_in_rdy),
        .out_data  (fifo_q),
        .out_valid (fifo_v),
        .out_ready (take_out)
    );

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            insn_r  <= '0;
            valid_r <= 1'b0;
        end
        else if (take_out)
        begin
            insn_r  <= fifo_q;
            valid_r <= 1'b1;
        end
        else if (CORE_READY)
            valid_r <= 1'b0;
    end
    assign CORE_INSN  = insn_r;
    assign CORE_VALID = valid_r;

    property p_tms_reset;
        @(posedge TCK) disable iff (!TRST_N)
        TMS [*5] |=> (st_r == jtdp_pkg::JTDP_RESET);
    endproperty
    a_tms_reset: assert property (p_tms_reset) else $error("five TMS highs not in reset");

    property p_idle_hold;
        @(posedge TCK) disable iff (!TRST_N)
        (st_r == jtdp_pkg::JTDP_IDLE) && !TMS |=> (st_r == jtdp_pkg::JTDP_IDLE);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("idle left without TMS");

    property p_shift_in;
        @(posedge TCK) disable iff (!TRST_N)
        sh_dr && !sel_byp |=> (dr_r[jtdp_pkg::DR_W-1] == $past(TDI));
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("TDI not shifted in");

    // Value seen at the rise must still stand at the following fall
    logic tdo_seen_r;
    always_ff @(posedge TCK or negedge TRST_N)
    begin
        if (!TRST_N)
            tdo_seen_r <= 1'b0;
        else
            tdo_seen_r <= tdo_r;
    end
    property p_tdo_fall;
        @(negedge TCK) disable iff (!TRST_N)
        TDO_O == tdo_seen_r;
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("TDO moved on rising edge");

    property p_trst;
        @(posedge TCK) !TRST_N |-> (st_r == jtdp_pkg::JTDP_RESET);
    endproperty
    a_trst: assert property (p_trst) else $error("test reset ignored");

    property p_update_tgl;
        @(posedge TCK) disable iff (!TRST_N)
        upd_dr && sel_exe |=> (tgl_r != $past(tgl_r)) && (word_r == $past(dr_r));
    endproperty
    a_update_tgl: assert property (p_update_tgl) else $error("word not handed over");

    property p_oe_idle;
        @(negedge TCK) disable iff (!TRST_N)
        (st_r == jtdp_pkg::JTDP_IDLE) |=> !TDO_OE;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("TDO driven outside shift");

    sequence s_word_seen;
        new_word && fifo_in_rdy;
    endsequence
    property p_core_gets;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        s_word_seen ##1 !CORE_VALID |=> CORE_VALID;
    endproperty
    a_core_gets: assert property (p_core_gets) else $error("word never reached core");
endmodule

// *** shared/jtdp_pkg.sv ***
// Package for the test access port debug block.
// Assumes a system clock domain and a separate probe-driven test clock.
package jtdp_pkg;
    localparam int IR_W          = 4;
    localparam int DR_W          = 32;
    localparam int FIFO_DEPTH    = 32;
    localparam int FIFO_AW       = 5;
    localparam logic [3:0] IR_RESET    = 4'h1;
    localparam logic [3:0] IR_BYPASS   = 4'hF;
    localparam logic [3:0] IR_IDCODE   = 4'hE;
    localparam logic [3:0] IR_EXEC     = 4'h8;
    localparam logic [3:0] IR_STATUS   = 4'h9;
    // Identity value is arbitrary
    localparam logic [31:0] ID_VALUE   = 32'h1234_5A5B;

    typedef enum logic [3:0] {
        JTDP_RESET      = 4'h0,
        JTDP_IDLE       = 4'h1,
        JTDP_SEL_DR     = 4'h2,
        JTDP_CAP_DR     = 4'h3,
        JTDP_SH_DR      = 4'h4,
        JTDP_EX1_DR     = 4'h5,
        JTDP_PAU_DR     = 4'h6,
        JTDP_EX2_DR     = 4'h7,
        JTDP_UPD_DR     = 4'h8,
        JTDP_SEL_IR     = 4'h9,
        JTDP_CAP_IR     = 4'hA,
        JTDP_SH_IR      = 4'hB,
        JTDP_EX1_IR     = 4'hC,
        JTDP_PAU_IR     = 4'hD,
        JTDP_EX2_IR     = 4'hE,
        JTDP_UPD_IR     = 4'hF
    } jtdp_state_t;
endpackage

// *** tb/jtdp_probe.sv ***
// Host probe model: drives the test link and takes the data output.
// Assumes the bench calls one task at a time; TCK rests low between frames.
`timescale 1ns/1ps

module jtdp_probe (
    // Link to device
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst_n,
    // Returned data
    input  wire logic tdo,
    input  wire logic tdo_en
);
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        // High at start so the first test reset is a real edge
        trst_n = 1'b1;
    end

    // Inputs move while TCK is low; TDO taken at the rise
    task automatic tick(input logic m, input logic d, output logic [1:0] q);
        tms = m;
        tdi = d;
        #24;
        tck = 1'b1;
        q = {tdo_en, tdo};
        #24;
        tck = 1'b0;
    endtask

    // Idle TDI toggles so a stale level is never mistaken for data
    task automatic shift(input logic ir, input int n, input logic [31:0] din,
                         output logic [31:0] dout, output logic oe_all);
        logic [1:0] q;
        dout = '0;
        oe_all = 1'b1;
        tick(1'b1, ~tdi, q);
        if (ir)
            tick(1'b1, ~tdi, q);
        tick(1'b0, ~tdi, q);
        tick(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], q);
            dout[i] = q[0];
            oe_all = oe_all & q[1];
        end
        tick(1'b1, ~tdi, q);
        tick(1'b0, ~tdi, q);
    endtask

    task automatic hard_reset();
        logic [1:0] q;
        trst_n = 1'b0;
        tick(1'b1, ~tdi, q);
        trst_n = 1'b1;
        tick(1'b0, ~tdi, q);
    endtask

    task automatic soft_reset();
        logic [1:0] q;
        repeat (5) tick(1'b1, ~tdi, q);
        tick(1'b0, ~tdi, q);
    endtask
endmodule

// *** tb/jtdp_top_bench.sv ***
// Bench for the test port: probe model on the link, core words checked by queue.
// Assumes exec words fill a 32-word FIFO plus the core port register; extras drop.
`timescale 1ns/1ps

module jtdp_top_bench;
    logic        clk_sys;
    logic        reset_n;
    logic        core_ready;
    logic        core_halted;
    logic        stall;
    logic        tck, tms, tdi, trst_n;
    logic        tdo_o, tdo_oe, core_valid;
    logic [31:0] core_insn;
    logic [31:0] dout;
    logic [31:0] w;
    logic [1:0]  q;
    logic        oe_all;
    logic        h;
    logic [31:0] exp_q[$];
    int          failures = 0;
    int          num_checks = 0;
    localparam logic [3:0] BYP [2] = '{jtdp_pkg::IR_BYPASS, jtdp_pkg::IR_RESET};

    jtdp_top uut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .TCK(tck), .TMS(tms),
        .TDI(tdi), .TRST_N(trst_n), .TDO_O(tdo_o), .TDO_OE(tdo_oe),
        .CORE_INSN(core_insn), .CORE_VALID(core_valid), .CORE_READY(core_ready),
        .CORE_HALTED(core_halted));
    jtdp_probe probe (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
        .tdo(tdo_o), .tdo_en(tdo_oe));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (failures == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic set_ir(input logic [3:0] code);
        probe.shift(1'b1, 4, {28'h0, code}, dout, oe_all);
        check(dout[3:0], 4'h1);
    endtask

    task automatic exec_words(input int n, input int keep);
        set_ir(jtdp_pkg::IR_EXEC);
        for (int k = 0; k < n; k++)
        begin
            w = $urandom;
            if (k < keep)
                exp_q.push_back(w);
            probe.shift(1'b0, 32, w, dout, oe_all);
        end
    endtask

    task automatic drain();
        stall = 1'b0;
        for (int t = 0; t < 3000 && exp_q.size() > 0; t++)
            @(posedge clk_sys);
        // Linger so a stray extra word still meets the checker
        repeat (16) @(posedge clk_sys);
        check(exp_q.size(), 32'h0);
        check(core_valid, 1'b0);
    endtask

    // Random back-pressure from the core
    always @(posedge clk_sys)
        core_ready <= ~stall & 1'($urandom);

    // Words leave in shift order, none invented
    always @(posedge clk_sys)
        if (core_valid === 1'b1 && core_ready === 1'b1)
            check(core_insn, exp_q.size() ? exp_q.pop_front() : 32'hXXXX_XXXX);

    initial
    begin
        reset_n = 1'b0;
        core_ready = 1'b0;
        core_halted = 1'b0;
        stall = 1'b1;
        void'($urandom(32'hEB8E));
        fork
            begin
                #400us;
                failures++;
                results();
            end
        join_none
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        probe.hard_reset();
        probe.shift(1'b0, 32, $urandom, dout, oe_all);
        check(dout, jtdp_pkg::ID_VALUE);
        check(oe_all, 1'b1);
        check(tdo_oe, 1'b0);
        foreach (BYP[k])
        begin
            set_ir(BYP[k]);
            w = $urandom;
            probe.shift(1'b0, 8, w, dout, oe_all);
            check(dout[7:0], {w[6:0], 1'b0});
        end
        probe.soft_reset();
        probe.shift(1'b0, 32, $urandom, dout, oe_all);
        check(dout, jtdp_pkg::ID_VALUE);
        set_ir(jtdp_pkg::IR_BYPASS);
        // Test reset in the middle of an instruction shift
        for (int k = 0; k < 6; k++)
            probe.tick(k < 2, 1'b0, q);
        check(tdo_oe, 1'b1);
        probe.hard_reset();
        probe.shift(1'b0, 32, $urandom, dout, oe_all);
        check(dout, jtdp_pkg::ID_VALUE);
        h = 1'($urandom);
        @(posedge clk_sys);
        core_halted <= h;
        set_ir(jtdp_pkg::IR_STATUS);
        probe.shift(1'b0, 32, $urandom, dout, oe_all);
        check(dout[1:0], {h, 1'b1});
        // Fill past capacity while the core stalls; the port register holds one more
        exec_words(jtdp_pkg::FIFO_DEPTH + 2, jtdp_pkg::FIFO_DEPTH + 1);
        set_ir(jtdp_pkg::IR_STATUS);
        probe.shift(1'b0, 32, $urandom, dout, oe_all);
        check(dout[0], 1'b0);
        drain();
        exec_words(4, 4);
        drain();
        check(tdo_oe, 1'b0);
        results();
    end
endmodule
